// [irna_controller.sv]
// i2c controller end: axi4-lite command registers driving single-byte transfers
`timescale 1ns/1ps
`include "irna_params.svh"
module irna_controller import irna_pkg::*; #(
  parameter int QTR = `IRNA_HOST_QTR
) (
  input wire logic clk,
  input wire logic rst_b,
  irna_link_if.host lnk,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  irna_host_s r;
  irna_host_s n;
  logic tick;
  logic rx;
  logic [2:0] stop_step;

  // ----------------------------------------
  // sequence step entry
  // ----------------------------------------
  // write: start, addr+w, reg, data, stop; read swaps data for restart, addr+r, one byte
  function automatic irna_host_s enter(input irna_host_s s, input logic [2:0] step);
    logic [7:0] b;
    case (step)
      3'h1: b = {s.tgt, 1'b0};
      3'h2: b = s.radr;
      3'h3: b = s.wdat;
      3'h4: b = {s.tgt, 1'b1};
      default: b = 8'h00;
    endcase
    s.step = step;
    s.q = 2'h0;
    s.div = 8'h00;
    s.bitn = 4'h0;
    if (step == 3'h0 || (s.rdcmd && step == `IRNA_STEP_R_RESTART)) begin
      s.st = H_START;
      s.sda_v = 1'b1;
    end else if (step == (s.rdcmd ? `IRNA_STEP_R_STOP : `IRNA_STEP_W_STOP)) begin
      s.st = H_STOP;
      s.sda_v = 1'b0;
    end else begin
      s.st = H_BIT;
      s.sh = b;
      s.sda_v = (s.rdcmd && step == `IRNA_STEP_R_RX) ? 1'b1 : b[7];
    end
    return s;
  endfunction

  assign tick = (r.div == 8'(QTR - 1));
  assign rx = r.rdcmd && r.step == `IRNA_STEP_R_RX;
  assign stop_step = r.rdcmd ? `IRNA_STEP_R_STOP : `IRNA_STEP_W_STOP;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = r;
    n.sda_sy = {r.sda_sy[0], lnk.sda};
    if (r.st != H_IDLE) begin
      n.div = tick ? 8'h00 : r.div + 8'h01;
      if (tick) n.q = r.q + 2'h1;
    end
    // axi write: address and data taken in either order, answered after both
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got = 1'b1;
      n.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got = 1'b1;
      n.w_d = s_axi_wdata[7:0];
      n.w_s = s_axi_wstrb[0];
    end
    if (r.bvalid && s_axi_bready) n.bvalid = 1'b0;
    if (r.rvalid && s_axi_rready) n.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp = `IRNA_RESP_OKAY;
      case (s_axi_araddr)
        `IRNA_AXI_TARGET: n.rdat = {1'b0, r.tgt};
        `IRNA_AXI_REGADDR: n.rdat = r.radr;
        `IRNA_AXI_WDATA: n.rdat = r.wdat;
        `IRNA_AXI_CMD: n.rdat = 8'h00;
        `IRNA_AXI_STATUS: n.rdat = {6'h00, r.nack, r.busy};
        `IRNA_AXI_RDATA: n.rdat = r.rbyte;
        default: begin
          n.rdat = 8'h00;
          n.rresp = `IRNA_RESP_SLVERR;
        end
      endcase
    end
    case (r.st)
      H_START: begin
        if (tick) begin
          case (r.q)
            2'h0: n.scl_v = 1'b1;
            2'h1: n.sda_v = 1'b0;
            2'h2: n.scl_v = 1'b0;
            default: n = enter(n, r.step + 3'h1);
          endcase
        end
      end
      H_BIT: begin
        if (tick) begin
          case (r.q)
            2'h0: n.scl_v = 1'b1;
            2'h2: begin
              n.scl_v = 1'b0;
              if (r.bitn == 4'h8) begin
                if (!rx && r.sda_sy[1]) n.nack = 1'b1;
              end else if (rx) begin
                n.sh = {r.sh[6:0], r.sda_sy[1]};
              end
            end
            2'h3: begin
              if (r.bitn == 4'h8) begin
                if (rx) n.rbyte = r.sh;
                // a refused byte ends the transfer at once
                if (r.nack) n = enter(n, stop_step);
                else n = enter(n, r.step + 3'h1);
              end else begin
                n.bitn = r.bitn + 4'h1;
                if (r.bitn == 4'h7 || rx) begin
                  n.sda_v = 1'b1;
                end else begin
                  n.sh = {r.sh[6:0], 1'b0};
                  n.sda_v = r.sh[6];
                end
              end
            end
            default: n.scl_v = 1'b1;
          endcase
        end
      end
      H_STOP: begin
        if (tick) begin
          case (r.q)
            2'h0: n.scl_v = 1'b1;
            2'h1: n.sda_v = 1'b1;
            2'h3: begin
              n.st = H_IDLE;
              n.busy = 1'b0;
            end
            default: n.sda_v = 1'b1;
          endcase
        end
      end
      default: n.div = 8'h00;
    endcase
    if (r.aw_got && r.w_got) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `IRNA_RESP_OKAY;
      case (r.aw_a)
        `IRNA_AXI_TARGET: if (r.w_s) n.tgt = r.w_d[6:0];
        `IRNA_AXI_REGADDR: if (r.w_s) n.radr = r.w_d;
        `IRNA_AXI_WDATA: if (r.w_s) n.wdat = r.w_d;
        `IRNA_AXI_CMD: begin
          // commands while busy are dropped; software polls status first
          if (r.w_s && !r.busy && (r.w_d[`IRNA_CMD_WR] || r.w_d[`IRNA_CMD_RD])) begin
            n.busy = 1'b1;
            n.nack = 1'b0;
            n.rdcmd = r.w_d[`IRNA_CMD_RD];
            n = enter(n, 3'h0);
          end
        end
        `IRNA_AXI_STATUS: n.bresp = `IRNA_RESP_OKAY;
        `IRNA_AXI_RDATA: n.bresp = `IRNA_RESP_OKAY;
        default: n.bresp = `IRNA_RESP_SLVERR;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r <= '0;
      r.st <= H_IDLE;
      r.scl_v <= 1'b1;
      r.sda_v <= 1'b1;
      r.sda_sy <= 2'h3;
      r.tgt <= `IRNA_TADDR_LH;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign lnk.host_scl_o = 1'b0;
  assign lnk.host_scl_oe_b = r.scl_v;
  assign lnk.host_sda_o = 1'b0;
  assign lnk.host_sda_oe_b = r.sda_v;
  assign s_axi_awready = ~r.aw_got & ~r.bvalid;
  assign s_axi_wready = ~r.w_got & ~r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = ~r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = {24'h000000, r.rdat};
  assign s_axi_rresp = r.rresp;
endmodule

// [irna_link_checker.sv]
// assertions on the shared two-wire link
`timescale 1ns/1ps
module irna_link_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic host_scl_o,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_b,
  input wire logic dev_scl_oe_b,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_b,
  input wire logic scl
);
  // ----------------------------------------
  // link properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_dev_no_stretch: assert property (dev_scl_oe_b) else $error("target drove scl");
  a_drain_data_low: assert property (!host_scl_o && !host_sda_o && !dev_sda_o) else $error("data not low");
  a_dev_grab_low: assert property ($fell(dev_sda_oe_b) |-> !scl) else $error("sda taken, scl high");
  a_dev_free_low: assert property ($rose(dev_sda_oe_b) |-> !scl) else $error("sda freed, scl high");
  a_dev_bit_hold: assert property ($fell(dev_sda_oe_b) |-> !dev_sda_oe_b [*8]) else $error("bit too short");
  // the target may never frame: sda moves only while scl is low
  a_dev_no_frame: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_b)) else $error("target framed");
  a_scl_low_span: assert property ($fell(scl) |-> !scl [*4]) else $error("scl low too short");
  a_idle_after_rst: assert property ($rose(rst_b) |-> host_sda_oe_b && dev_sda_oe_b) else $error("not idle");
endmodule

// [irna_link_if.sv]
// open-drain two-wire link joining controller and target
`timescale 1ns/1ps
interface irna_link_if;
  logic host_scl_o;
  logic host_scl_oe_b;
  logic host_sda_o;
  logic host_sda_oe_b;
  logic dev_scl_o;
  logic dev_scl_oe_b;
  logic dev_sda_o;
  logic dev_sda_oe_b;
  logic scl;
  logic sda;
  // wired-and with pull-up: low when any enabled driver pulls low
  assign scl = ~((~host_scl_oe_b & ~host_scl_o) | (~dev_scl_oe_b & ~dev_scl_o));
  assign sda = ~((~host_sda_oe_b & ~host_sda_o) | (~dev_sda_oe_b & ~dev_sda_o));
  modport host (output host_scl_o, output host_scl_oe_b, output host_sda_o, output host_sda_oe_b,
                input scl, input sda);
  modport dev (output dev_scl_o, output dev_scl_oe_b, output dev_sda_o, output dev_sda_oe_b,
               input scl, input sda);
endinterface

// [irna_params.svh]
// constants for the i2c register bank with nvm access
`ifndef IRNA_PARAMS_SVH
`define IRNA_PARAMS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define IRNA_CLK_NS 100
`define IRNA_NVM_STEP_NS 4000
`define IRNA_NVM_STEP_CYC ((`IRNA_NVM_STEP_NS + `IRNA_CLK_NS - 1) / `IRNA_CLK_NS)
`define IRNA_HOST_QTR 5
// ----------------------------------------
// device register map
// ----------------------------------------
`define IRNA_NREG 26
`define IRNA_REG_FAULT 8'h00
`define IRNA_REG_LAST 8'h19
`define IRNA_REG_ADDR_SEL 5'h19
`define IRNA_REG_DIR 8'h56
`define IRNA_REG_GO 8'h57
`define IRNA_ADDR_SEL_RST 8'h52
`define IRNA_TADDR_LH 7'h29
`define IRNA_TADDR_HL 7'h2d
`define IRNA_TADDR_HH 7'h32
`define IRNA_GO_START 8'h01
`define IRNA_GO_IDLE 8'h00
`define IRNA_NVM_FIRST 5'h01
`define IRNA_R_HALT 5'h02
`define IRNA_R_LSPD_H 5'h06
`define IRNA_R_LSPD_L 5'h07
`define IRNA_R_GRAD1_H 5'h08
`define IRNA_R_GRAD1_L 5'h09
`define IRNA_R_GRAD2_H 5'h0a
`define IRNA_R_GRAD2_L 5'h0b
`define IRNA_R_KI 5'h0c
`define IRNA_R_KP 5'h0d
`define IRNA_R_MCFG_A 5'h0e
`define IRNA_R_MCFG_B 5'h0f
`define IRNA_R_PROT 5'h10
`define IRNA_B_LOOP 0
`define IRNA_B_PUMP_DIS 1
`define IRNA_B_X8 7
`define IRNA_B_SPD_TYPE 4
`define IRNA_B_SPD_INV 3
`define IRNA_B_LATCH 2
`define IRNA_B_NOHALT 7
`define IRNA_B_OPEN_UP 1
`define IRNA_B_FULL_OFF 0
`define IRNA_B_STALL 7
`define IRNA_B_DIR_POL 6
// ----------------------------------------
// controller axi registers and sequence steps
// ----------------------------------------
`define IRNA_AXI_TARGET 8'h00
`define IRNA_AXI_REGADDR 8'h04
`define IRNA_AXI_WDATA 8'h08
`define IRNA_AXI_CMD 8'h0c
`define IRNA_AXI_STATUS 8'h10
`define IRNA_AXI_RDATA 8'h14
`define IRNA_CMD_WR 0
`define IRNA_CMD_RD 1
`define IRNA_RESP_OKAY 2'h0
`define IRNA_RESP_SLVERR 2'h2
`define IRNA_STEP_W_STOP 3'h4
`define IRNA_STEP_R_RESTART 3'h3
`define IRNA_STEP_R_RX 3'h5
`define IRNA_STEP_R_STOP 3'h6
`endif

// [irna_pkg.sv]
// types shared by both ends of the i2c register link
`include "irna_params.svh"
package irna_pkg;
  typedef enum logic [4:0] {D_IDLE = 5'h01, D_RX = 5'h02, D_ACK = 5'h04, D_TX = 5'h08, D_RACK = 5'h10} irna_dst_e;
  typedef enum logic [2:0] {K_ADDR = 3'h1, K_REG = 3'h2, K_DATA = 3'h4} irna_kind_e;
  typedef enum logic [3:0] {H_IDLE = 4'h1, H_START = 4'h2, H_BIT = 4'h4, H_STOP = 4'h8} irna_hst_e;
  typedef struct packed {
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [5:0] flt_s1;
    logic [5:0] flt_s2;
    irna_dst_e st;
    irna_kind_e kind;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic nack;
    logic sda_low;
    logic [`IRNA_NREG-1:0][7:0] regs;
    logic [`IRNA_NREG-1:0][7:0] nvm;
    logic dir;
    logic [7:0] go;
    logic [4:0] idx;
    logic [15:0] tmr;
  } irna_dev_s;
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_a;
    logic w_got;
    logic [7:0] w_d;
    logic w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdat;
    logic [6:0] tgt;
    logic [7:0] radr;
    logic [7:0] wdat;
    logic busy;
    logic nack;
    logic rdcmd;
    logic [7:0] rbyte;
    irna_hst_e st;
    logic [2:0] step;
    logic [1:0] q;
    logic [7:0] div;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic scl_v;
    logic sda_v;
    logic [1:0] sda_sy;
  } irna_host_s;
endpackage

// [irna_target.sv]
// i2c target end: register bank, address select and nvm copy engine
`timescale 1ns/1ps
`include "irna_params.svh"
module irna_target import irna_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  irna_link_if.dev lnk,
  input wire logic addr_select_pin_a,
  input wire logic addr_select_pin_b,
  input wire logic pump_undervoltage_flag,
  input wire logic over_temp_flag,
  input wire logic over_current_flag,
  input wire logic overspeed_flag,
  input wire logic underspeed_flag,
  input wire logic startup_fault_flag,
  output logic loop_select,
  output logic pump_monitor_disable,
  output logic [9:0] integral_gain_eff,
  output logic [9:0] proportional_gain_eff,
  output logic speed_input_type,
  output logic speed_input_invert,
  output logic fault_latch_mode,
  output logic never_halt_enable,
  output logic open_above_upper_enable,
  output logic full_speed_when_off,
  output logic stall_guard_disable,
  output logic direction_polarity,
  output logic [11:0] launch_speed,
  output logic [13:0] curve_gradient_one,
  output logic [13:0] curve_gradient_two,
  output logic nvm_busy
);
  irna_dev_s r;
  irna_dev_s n;
  logic scl_rise;
  logic scl_fall;
  logic sda_v;
  logic bus_start;
  logic bus_stop;
  logic [6:0] own_addr;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  function automatic logic [7:0] rd_byte(input logic [7:0] a, input irna_dev_s s);
    logic [7:0] v;
    v = 8'h00;
    if (a == `IRNA_REG_FAULT) v = {2'h0, s.flt_s2};
    else if (a <= `IRNA_REG_LAST) v = s.regs[a[4:0]];
    else if (a == `IRNA_REG_DIR) v = {7'h00, s.dir};
    else if (a == `IRNA_REG_GO) v = s.go;
    return v;
  endfunction

  // ----------------------------------------
  // line conditions
  // ----------------------------------------
  // only the second and third sync stages are looked at
  assign scl_rise = r.scl_sy[1] & ~r.scl_sy[2];
  assign scl_fall = ~r.scl_sy[1] & r.scl_sy[2];
  assign sda_v = r.sda_sy[1];
  assign bus_start = r.scl_sy[1] & r.scl_sy[2] & ~r.sda_sy[1] & r.sda_sy[2];
  assign bus_stop = r.scl_sy[1] & r.scl_sy[2] & r.sda_sy[1] & ~r.sda_sy[2];

  always_comb begin
    case (r.pin_s2)
      2'h1: own_addr = `IRNA_TADDR_LH;
      2'h2: own_addr = `IRNA_TADDR_HL;
      2'h3: own_addr = `IRNA_TADDR_HH;
      default: own_addr = r.regs[`IRNA_REG_ADDR_SEL][7:1];
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = r;
    n.scl_sy = {r.scl_sy[1:0], lnk.scl};
    n.sda_sy = {r.sda_sy[1:0], lnk.sda};
    n.pin_s1 = {addr_select_pin_b, addr_select_pin_a};
    n.pin_s2 = r.pin_s1;
    n.flt_s1 = {pump_undervoltage_flag, over_temp_flag, over_current_flag, overspeed_flag, underspeed_flag,
                startup_fault_flag};
    n.flt_s2 = r.flt_s1;
    // one byte per step; go stays at its start value until the last byte, or until an idle write to go while dir is set
    if (r.go != `IRNA_GO_IDLE) begin
      n.tmr = r.tmr + 16'h0001;
      if (r.tmr == 16'(`IRNA_NVM_STEP_CYC - 1)) begin
        n.tmr = 16'h0000;
        if (r.dir) n.nvm[r.idx] = r.regs[r.idx];
        else n.regs[r.idx] = r.nvm[r.idx];
        if (r.idx == `IRNA_REG_ADDR_SEL) n.go = `IRNA_GO_IDLE;
        else n.idx = r.idx + 5'h01;
      end
    end
    if (bus_stop) begin
      n.st = D_IDLE;
      n.sda_low = 1'b0;
    end else if (bus_start) begin
      n.st = D_RX;
      n.bitn = 4'h0;
      n.kind = K_ADDR;
      n.rw = 1'b0;
      n.sda_low = 1'b0;
    end else begin
      case (r.st)
        D_RX: begin
          if (scl_rise) begin
            n.sh = {r.sh[6:0], sda_v};
            n.bitn = r.bitn + 4'h1;
          end else if (scl_fall && r.bitn == 4'h8) begin
            n.bitn = 4'h0;
            n.st = D_ACK;
            n.sda_low = 1'b1;
            case (r.kind)
              K_ADDR: begin
                n.kind = K_REG;
                n.rw = r.sh[0];
                if (r.sh[7:1] != own_addr) begin
                  n.st = D_IDLE;
                  n.sda_low = 1'b0;
                end
              end
              K_REG: begin
                n.kind = K_DATA;
                n.ptr = r.sh;
              end
              default: begin
                // an earlier engine step on the same cycle is overridden by the bus write
                if (r.ptr != `IRNA_REG_FAULT && r.ptr <= `IRNA_REG_LAST) n.regs[r.ptr[4:0]] = r.sh;
                else if (r.ptr == `IRNA_REG_DIR) n.dir = r.sh[0];
                else if (r.ptr == `IRNA_REG_GO) begin
                  if (r.sh == `IRNA_GO_START && r.go == `IRNA_GO_IDLE) begin
                    n.go = `IRNA_GO_START;
                    n.idx = `IRNA_NVM_FIRST;
                    n.tmr = 16'h0000;
                  end else if (r.sh == `IRNA_GO_IDLE && r.dir) begin
                    n.go = `IRNA_GO_IDLE;
                  end
                end
                n.ptr = r.ptr + 8'h01;
              end
            endcase
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            n.bitn = 4'h0;
            if (r.rw) begin
              n.st = D_TX;
              n.sh = rd_byte(r.ptr, r);
              n.sda_low = ~n.sh[7];
            end else begin
              n.st = D_RX;
              n.sda_low = 1'b0;
            end
          end
        end
        D_TX: begin
          if (scl_fall) begin
            if (r.bitn == 4'h7) begin
              n.st = D_RACK;
              n.sda_low = 1'b0;
            end else begin
              n.sh = {r.sh[6:0], 1'b0};
              n.sda_low = ~r.sh[6];
              n.bitn = r.bitn + 4'h1;
            end
          end
        end
        D_RACK: begin
          if (scl_rise) begin
            n.nack = sda_v;
          end else if (scl_fall) begin
            if (r.nack) begin
              n.st = D_IDLE;
            end else begin
              n.ptr = r.ptr + 8'h01;
              n.sh = rd_byte(r.ptr + 8'h01, r);
              n.sda_low = ~n.sh[7];
              n.bitn = 4'h0;
              n.st = D_TX;
            end
          end
        end
        default: n.sda_low = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // nvm contents are modelled as cleared by reset apart from the address byte
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r <= '0;
      r.st <= D_IDLE;
      r.kind <= K_ADDR;
      r.scl_sy <= 3'h7;
      r.sda_sy <= 3'h7;
      r.regs[`IRNA_REG_ADDR_SEL] <= `IRNA_ADDR_SEL_RST;
      r.nvm[`IRNA_REG_ADDR_SEL] <= `IRNA_ADDR_SEL_RST;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign lnk.dev_scl_o = 1'b0;
  assign lnk.dev_scl_oe_b = 1'b1;
  assign lnk.dev_sda_o = 1'b0;
  assign lnk.dev_sda_oe_b = ~r.sda_low;
  assign loop_select = r.regs[`IRNA_R_GRAD2_L][`IRNA_B_LOOP];
  assign pump_monitor_disable = r.regs[`IRNA_R_GRAD2_L][`IRNA_B_PUMP_DIS];
  assign integral_gain_eff = r.regs[`IRNA_R_KI][`IRNA_B_X8] ? {r.regs[`IRNA_R_KI][6:0], 3'h0} :
                             {3'h0, r.regs[`IRNA_R_KI][6:0]};
  assign proportional_gain_eff = r.regs[`IRNA_R_KP][`IRNA_B_X8] ? {r.regs[`IRNA_R_KP][6:0], 3'h0} :
                                 {3'h0, r.regs[`IRNA_R_KP][6:0]};
  assign speed_input_type = r.regs[`IRNA_R_MCFG_B][`IRNA_B_SPD_TYPE];
  assign speed_input_invert = r.regs[`IRNA_R_MCFG_B][`IRNA_B_SPD_INV];
  assign fault_latch_mode = r.regs[`IRNA_R_MCFG_B][`IRNA_B_LATCH];
  assign never_halt_enable = r.regs[`IRNA_R_HALT][`IRNA_B_NOHALT];
  assign open_above_upper_enable = r.regs[`IRNA_R_GRAD1_L][`IRNA_B_OPEN_UP];
  assign full_speed_when_off = r.regs[`IRNA_R_GRAD1_L][`IRNA_B_FULL_OFF];
  assign stall_guard_disable = r.regs[`IRNA_R_PROT][`IRNA_B_STALL];
  assign direction_polarity = r.regs[`IRNA_R_MCFG_A][`IRNA_B_DIR_POL];
  assign launch_speed = {r.regs[`IRNA_R_LSPD_H], r.regs[`IRNA_R_LSPD_L][7:4]};
  assign curve_gradient_one = {r.regs[`IRNA_R_GRAD1_H], r.regs[`IRNA_R_GRAD1_L][7:2]};
  assign curve_gradient_two = {r.regs[`IRNA_R_GRAD2_H], r.regs[`IRNA_R_GRAD2_L][7:2]};
  assign nvm_busy = (r.go != `IRNA_GO_IDLE);
endmodule

// [tb.sv]
// bench: controller and target joined on one link
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] pin = 2'h0;
  logic [5:0] flt = 6'h2a;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, st, rdw;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic loop_select, pump_monitor_disable, speed_input_type, speed_input_invert, fault_latch_mode, nvm_busy;
  logic never_halt_enable, open_above_upper_enable, full_speed_when_off, stall_guard_disable, direction_polarity;
  logic [9:0] integral_gain_eff, proportional_gain_eff;
  logic [11:0] launch_speed;
  logic [13:0] curve_gradient_one, curve_gradient_two;
  logic [7:0] ra [10] = '{8'h02, 8'h06, 8'h07, 8'h09, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10};
  logic [7:0] va [10] = '{8'h80, 8'h12, 8'h30, 8'hab, 8'hfe, 8'h85, 8'h05, 8'h40, 8'h1c, 8'h80};
  logic [6:0] ta [4] = '{7'h2a, 7'h29, 7'h2d, 7'h32};
  int mismatches = 0;
  int checks_done = 0;
  always #50 clk = ~clk;
  irna_link_if lnk ();
  irna_controller #(.QTR(4)) u_irna_controller (.lnk(lnk), .*);
  irna_target u_irna_target (.lnk(lnk), .addr_select_pin_a(pin[0]), .addr_select_pin_b(pin[1]),
    .pump_undervoltage_flag(flt[5]), .over_temp_flag(flt[4]), .over_current_flag(flt[3]),
    .overspeed_flag(flt[2]), .underspeed_flag(flt[1]), .startup_fault_flag(flt[0]), .*);
  irna_link_checker u_irna_link_checker (.clk(clk), .rst_b(rst_b), .host_scl_o(lnk.host_scl_o),
    .host_sda_o(lnk.host_sda_o), .host_sda_oe_b(lnk.host_sda_oe_b), .dev_scl_oe_b(lnk.dev_scl_oe_b),
    .dev_sda_o(lnk.dev_sda_o), .dev_sda_oe_b(lnk.dev_sda_oe_b), .scl(lnk.scl));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  // address and data go out together; each is dropped once its own ready is seen
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
  endtask
  task automatic xfer(input logic [6:0] t, input logic [7:0] r, input logic [7:0] d, input logic rd);
    axw(8'h00, {25'h0, t});
    axw(8'h04, {24'h0, r});
    axw(8'h08, {24'h0, d});
    axw(8'h0c, {30'h0, rd, !rd});
    do axr(8'h10, st); while (st[0] !== 1'b0);
    axr(8'h14, rdw);
  endtask
  task automatic rc(input logic [6:0] t, input logic [7:0] r, input logic [7:0] e);
    xfer(t, r, 8'h00, 1'b1);
    chk(rdw, {24'h0, e});
  endtask
  // no wait figure is fixed, so poll until the go register reads idle
  task automatic poll();
    do xfer(7'h29, 8'h57, 8'h00, 1'b1); while (rdw[7:0] !== 8'h00);
    chk({31'h0, nvm_busy}, 32'h0);
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rc(7'h29, 8'h19, 8'h52);
    rc(7'h29, 8'h0b, 8'h00);
    rc(7'h29, 8'h00, 8'h2a);
    flt <= 6'h15;
    xfer(7'h29, 8'h00, 8'hff, 1'b0);
    rc(7'h29, 8'h00, 8'h15);
    xfer(7'h29, 8'h01, 8'ha5, 1'b0);
    rc(7'h29, 8'h01, 8'ha5);
    for (int i = 0; i < 10; i++) begin
      xfer(7'h29, ra[i], va[i], 1'b0);
    end
    chk({22'h0, never_halt_enable, open_above_upper_enable,
      full_speed_when_off, stall_guard_disable, direction_polarity, loop_select, pump_monitor_disable,
      speed_input_type, speed_input_invert, fault_latch_mode}, 32'h3ef);
    chk({integral_gain_eff, proportional_gain_eff, launch_speed}, {10'h028, 10'h005, 12'h123});
    chk({4'h0, curve_gradient_one, curve_gradient_two}, {4'h0, 14'h002a, 14'h003f});
    xfer(7'h29, 8'h56, 8'h01, 1'b0);
    xfer(7'h29, 8'h57, 8'h01, 1'b0);
    chk({31'h0, nvm_busy}, 32'h1);
    poll();
    xfer(7'h29, 8'h01, 8'h3c, 1'b0);
    xfer(7'h29, 8'h56, 8'h00, 1'b0);
    xfer(7'h29, 8'h57, 8'h01, 1'b0);
    poll();
    rc(7'h29, 8'h01, 8'ha5);
    // a store lasts far longer than one bus write, so the abort lands mid-transfer
    xfer(7'h29, 8'h56, 8'h01, 1'b0);
    xfer(7'h29, 8'h57, 8'h01, 1'b0);
    chk({31'h0, nvm_busy}, 32'h1);
    xfer(7'h29, 8'h57, 8'h00, 1'b0);
    chk({31'h0, nvm_busy}, 32'h0);
    rc(7'h29, 8'h57, 8'h00);
    xfer(7'h29, 8'h19, 8'h54, 1'b0);
    rc(7'h2a, 8'h01, 8'ha5);
    for (int p = 1; p < 4; p++) begin
      pin <= p[1:0];
      rc(ta[p], 8'h01, 8'ha5);
    end
    xfer(7'h2a, 8'h01, 8'h00, 1'b1);
    chk({31'h0, st[1]}, 32'h1);
    test_done();
  end
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule
